//--- pkg/pwr_defs.svh
`ifndef PWR_DEFS_SVH
`define PWR_DEFS_SVH
`define CLK_PERIOD_NS      100'd10
`define LONG_PRESS_S       4
`define LONG_PRESS_CYC     (`LONG_PRESS_S * 100000000)
`define DEBOUNCE_US        10
`define DEBOUNCE_CYC       (`DEBOUNCE_US * 1000 / 10)
`define CMD_NONE           3'h0
`define CMD_S1             3'h1
`define CMD_S2             3'h2
`define CMD_S3             3'h3
`define CMD_S4             3'h4
`define CMD_S5             3'h5
`define WAKE_LAN           0
`define WAKE_PME           1
`define WAKE_SW            2
`define WAKE_RTC           3
`define WAKE_SER           4
`define WAKE_PS2           5
`define WAKE_USB           6
`define WAKE_N             7
`endif

//--- pkg/pwr_pkg.sv
package pwr_pkg;
    typedef enum logic [2:0] {
        ST_S0 = 3'h0,
        ST_S1 = 3'h1,
        ST_S3 = 3'h3,
        ST_S4 = 3'h4,
        ST_S5 = 3'h5
    } pwr_state_e;
    typedef logic [2:0] sleep_cmd_t;
endpackage

//--- rtl/power_state_wake_controller.sv
`timescale 1ns/10ps
`include "pwr_defs.svh"
// Function
// - A switch press shorter than four seconds turns soft-off on, working to sleep, and sleep back on.
// - A press of four seconds or more while working or sleeping forces soft-off without software.
// - LAN and the power event request wake from S1, S3 and S4, and from S5 only when enabled.
// - Switch and RTC alarm wake from all sleep states; serial, PS/2 and USB only from S1 and S3.
// - Wake from S5 by LAN or the power event request is disabled after reset until software enables it.
// - Software commands all normal transitions; the block moves alone only on switch overrides and wakes.
// - A software soft-off command removes main power, leaving only standby wake logic alive.
// - Only S1, S3, S4 and S5 are accepted as sleep states; a request for S2 is refused.
// - USB activity counts as a wake event only from S1 and S3.
module power_state_wake_controller #(
    parameter int unsigned LONG_PRESS_CYCLES = `LONG_PRESS_CYC,
    parameter int unsigned DEBOUNCE_CYCLES   = `DEBOUNCE_CYC
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    // front panel
    input  wire logic               power_switch,
    // wake sources
    input  wire logic               lan_wake,
    input  wire logic               power_event_wake_request,
    input  wire logic               rtc_alarm,
    input  wire logic               serial_wake,
    input  wire logic               ps2_wake,
    input  wire logic               usb_wake,
    // software
    input  wire logic               s5_lan_pme_enable,
    input  wire logic               sleep_cmd_valid,
    input  wire pwr_pkg::sleep_cmd_t sleep_cmd,
    // status
    output logic                    sleep_cmd_reject,
    output pwr_pkg::pwr_state_e     pwr_state,
    output logic                    main_power_on,
    output logic                    wake_event
);
    import pwr_pkg::*;

    // ------------------------------------------------------------
    // switch debounce and press timing
    // ------------------------------------------------------------
    logic        sw_stable_r;
    logic [31:0] db_cnt_r;
    logic [31:0] press_cnt_r;
    logic        long_done_r;
    pwr_state_e  state_r;
    pwr_state_e  state_nxt;
    logic        reject_r;
    logic        wake_r;
    logic        power_r;

    wire db_diff    = (power_switch != sw_stable_r);
    wire db_expired = db_diff && (db_cnt_r >= DEBOUNCE_CYCLES - 1);
    wire sw_rel     = db_expired && sw_stable_r;
    // a long press acts while still held so the override never waits on the release
    wire long_hit   = sw_stable_r && !long_done_r &&
                      (press_cnt_r == LONG_PRESS_CYCLES - 1);
    wire short_rel  = sw_rel && !long_done_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_stable_r <= 1'b0;
            db_cnt_r    <= '0;
        end else begin
            sw_stable_r <= db_expired ? power_switch : sw_stable_r;
            db_cnt_r    <= (db_diff && !db_expired) ? db_cnt_r + 32'd1 : '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            press_cnt_r <= '0;
            long_done_r <= 1'b0;
        end else if (!sw_stable_r) begin
            press_cnt_r <= '0;
            long_done_r <= 1'b0;
        end else begin
            press_cnt_r <= long_done_r ? press_cnt_r : press_cnt_r + 32'd1;
            long_done_r <= long_done_r | long_hit;
        end
    end

    // ------------------------------------------------------------
    // wake qualification
    // ------------------------------------------------------------
    wire in_s1s3    = (state_r == ST_S1) || (state_r == ST_S3);
    wire in_sleep   = in_s1s3 || (state_r == ST_S4);
    wire in_s5      = (state_r == ST_S5);
    // enable is a live level from software; it is low out of reset by the caller's register
    wire lanpme_any = lan_wake | power_event_wake_request;
    wire wake_lp    = lanpme_any && (in_sleep || (in_s5 && s5_lan_pme_enable));
    wire wake_rtc   = rtc_alarm && (in_sleep || in_s5);
    wire wake_usb   = usb_wake && in_s1s3;
    wire wake_slow  = (serial_wake | ps2_wake) && in_s1s3;
    wire wake_any   = wake_lp | wake_rtc | wake_usb | wake_slow;

    // ------------------------------------------------------------
    // software command decode
    // ------------------------------------------------------------
    wire cmd_legal  = (sleep_cmd == `CMD_S1) || (sleep_cmd == `CMD_S3) ||
                      (sleep_cmd == `CMD_S4) || (sleep_cmd == `CMD_S5);
    wire cmd_take   = sleep_cmd_valid && cmd_legal && (state_r == ST_S0);
    wire cmd_bad    = sleep_cmd_valid && !cmd_take;

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_S0: begin
                if (long_hit) begin
                    state_nxt = ST_S5;
                end else if (short_rel) begin
                    state_nxt = ST_S1;
                end else if (cmd_take) begin
                    state_nxt = pwr_state_e'(sleep_cmd);
                end
            end
            ST_S1, ST_S3, ST_S4: begin
                if (long_hit) begin
                    state_nxt = ST_S5;
                end else if (short_rel || wake_any) begin
                    state_nxt = ST_S0;
                end
            end
            ST_S5: begin
                if (short_rel || wake_any) begin
                    state_nxt = ST_S0;
                end
            end
            default: state_nxt = ST_S5;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r  <= ST_S5;
            reject_r <= 1'b0;
            wake_r   <= 1'b0;
            power_r  <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            reject_r <= cmd_bad;
            wake_r   <= wake_any && (state_nxt == ST_S0) && !short_rel;
            // taken from the next state so the rail enable moves with the state, glitch free
            power_r  <= (state_nxt == ST_S0) || (state_nxt == ST_S1);
        end
    end

    assign pwr_state        = state_r;
    assign main_power_on    = power_r;
    assign sleep_cmd_reject = reject_r;
    assign wake_event       = wake_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence long_press_s;
        sw_stable_r && !long_done_r && (press_cnt_r == LONG_PRESS_CYCLES - 1);
    endsequence

    long_forces_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        long_press_s ##0 (state_r != ST_S5) |=> (state_r == ST_S5))
        else $error("long press did not force soft off");
    short_on_a: assert property (@(posedge clk) disable iff (!reset_n)
        (short_rel && state_r == ST_S5) |=> (state_r == ST_S0))
        else $error("short press did not power on");
    short_sleep_a: assert property (@(posedge clk) disable iff (!reset_n)
        (short_rel && !long_hit && state_r == ST_S0) |=> (state_r == ST_S1))
        else $error("short press did not enter sleep");
    s5_lan_block_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == ST_S5 && !s5_lan_pme_enable && !short_rel && !rtc_alarm) |=> (state_r == ST_S5))
        else $error("soft off left without enabled wake");
    usb_s4_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == ST_S4 && !long_hit && !short_rel && !rtc_alarm && !lanpme_any) |=> (state_r == ST_S4))
        else $error("usb or serial woke from s4");
    lan_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
        (lan_wake && in_sleep && !long_hit) |=> (state_r == ST_S0))
        else $error("lan wake ignored in sleep");
    reject_s2_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sleep_cmd_valid && sleep_cmd == `CMD_S2) |=> sleep_cmd_reject)
        else $error("s2 request was not refused");
    soft_off_power_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_take && sleep_cmd == `CMD_S5 && !long_hit && !short_rel) |=> (state_r == ST_S5) && !main_power_on)
        else $error("soft off kept main power");
    no_self_sleep_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == ST_S0 && !sleep_cmd_valid && !short_rel && !long_hit) |=> (state_r == ST_S0))
        else $error("left working state without cause");
    db_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(sw_stable_r) |-> $past(power_switch))
        else $error("debounced switch rose without input");

    // a qualified wake that no switch event overrides
    sequence wake_seen_s;
        wake_any && !long_hit && !short_rel;
    endsequence

    wake_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        wake_seen_s |=> wake_event && (state_r == ST_S0))
        else $error("wake did not reach working state");
    usb_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
        (usb_wake && in_s1s3 && !long_hit) |=> (state_r == ST_S0))
        else $error("usb activity ignored in light sleep");
    rtc_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rtc_alarm && (in_sleep || in_s5) && !long_hit) |=> (state_r == ST_S0))
        else $error("rtc alarm ignored");
    s5_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
        (lanpme_any && in_s5 && s5_lan_pme_enable) |=> (state_r == ST_S0))
        else $error("enabled soft off wake ignored");
    cmd_refused_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sleep_cmd_valid && (state_r != ST_S0)) |=> sleep_cmd_reject)
        else $error("command outside working state accepted");
    cmd_taken_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_take && !long_hit && !short_rel) |=> (state_r == pwr_state_e'($past(sleep_cmd))) && !sleep_cmd_reject)
        else $error("legal command not followed");
    rail_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == ST_S3 || state_r == ST_S4 || state_r == ST_S5) |-> !main_power_on)
        else $error("main power on in deep sleep");
    rail_on_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == ST_S0 || state_r == ST_S1) |-> main_power_on)
        else $error("main power off while running");
    no_s2_a: assert property (@(posedge clk) disable iff (!reset_n)
        (3'(state_r) != `CMD_S2))
        else $error("state machine entered s2");
    long_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
        long_hit |=> long_done_r && !long_hit)
        else $error("long press not latched once");
endmodule

//--- tb/panel_switch_model.sv
`timescale 1ns/10ps
module panel_switch_model (
    // bench side
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] hold,
    // front panel
    output logic            power_switch
);
    // ----------------------------------------
    // contact behaviour
    // ----------------------------------------
    initial begin
        power_switch = 1'b0;
        forever begin
            @(posedge clk);
            if (go === 1'b1) begin
                // a one-cycle bounce first, which must never count as a press
                #1 power_switch = 1'b1;
                @(posedge clk) #1 power_switch = 1'b0;
                @(posedge clk) #1 power_switch = 1'b1;
                repeat (hold) @(posedge clk);
                #1 power_switch = 1'b0;
            end
        end
    end
endmodule

//--- tb/test_power_state_wake_controller.sv
`timescale 1ns/10ps
`include "pwr_defs.svh"
module test_power_state_wake_controller;
    import pwr_pkg::*;
    // ----------------------------------------
    // signals and scoreboard notes
    // ----------------------------------------
    logic       clk = 0;
    logic       reset_n = 0;
    logic [6:0] wk = '0;
    logic       en = 0;
    logic       cv = 0;
    sleep_cmd_t cmd = '0;
    logic       go = 0;
    logic [7:0] hold = '0;
    logic       power_switch, rej, wev, mpo;
    pwr_state_e st;
    pwr_state_e last = ST_S5;
    pwr_state_e st_q[$];
    logic       rej_q[$];
    logic       wev_q[$];
    int         errors = 0;
    int         checks_done = 0;
    int         seed = 77;
    initial forever #5 clk = ~clk;
    // short counts keep the run small; expectations follow these values
    power_state_wake_controller #(.LONG_PRESS_CYCLES(50), .DEBOUNCE_CYCLES(3)) uut (
        .clk(clk), .reset_n(reset_n), .power_switch(power_switch), .lan_wake(wk[`WAKE_LAN]),
        .power_event_wake_request(wk[`WAKE_PME]), .rtc_alarm(wk[`WAKE_RTC]), .serial_wake(wk[`WAKE_SER]),
        .ps2_wake(wk[`WAKE_PS2]), .usb_wake(wk[`WAKE_USB]), .s5_lan_pme_enable(en), .sleep_cmd_valid(cv),
        .sleep_cmd(cmd), .sleep_cmd_reject(rej), .pwr_state(st), .main_power_on(mpo), .wake_event(wev));
    panel_switch_model sw (.clk(clk), .go(go), .hold(hold), .power_switch(power_switch));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic report_and_stop;
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp_state(pwr_state_e got, pwr_state_e exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected state at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(logic got, logic exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic send(sleep_cmd_t c, bit refused);
        if (refused) rej_q.push_back(1'b1);
        else st_q.push_back(pwr_state_e'(c));
        cv = 1;
        cmd = c;
        step(1);
        cv = 0;
        step(1);
    endtask
    // bounded wait for the state to move, then let release and debounce settle
    task automatic press(int n, pwr_state_e exp);
        int k;
        pwr_state_e prev;
        prev = st;
        st_q.push_back(exp);
        hold = 8'(n);
        go = 1;
        step(1);
        go = 0;
        for (k = 0; k < n + 30 && st === prev; k++) step(1);
        cmp_flag(st === prev, 1'b0);
        if (st === prev) report_and_stop;
        step(n + 8);
    endtask
    function automatic bit wake_ok(int src, pwr_state_e s, bit e);
        if (src <= `WAKE_PME) return s != ST_S5 || e;
        if (src == `WAKE_RTC) return 1;
        return s == ST_S1 || s == ST_S3;
    endfunction
    // ----------------------------------------
    // output watcher
    // ----------------------------------------
    always @(posedge clk) begin
        #2;
        if (reset_n && st !== last) begin
            if (st_q.size() == 0) cmp_state(st, last);
            else cmp_state(st, st_q.pop_front());
            cmp_flag(mpo, st == ST_S0 || st == ST_S1);
            last = st;
        end
        if (rej === 1'b1) cmp_flag(rej, rej_q.size() ? rej_q.pop_front() : 1'b0);
        if (wev === 1'b1) cmp_flag(wev, wev_q.size() ? wev_q.pop_front() : 1'b0);
    end
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        report_and_stop;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        pwr_state_e sl[4];
        bit a;
        sl = '{ST_S1, ST_S3, ST_S4, ST_S5};
        step(16);
        reset_n = 1;
        step(2);
        cmp_state(st, ST_S5);
        cmp_flag(mpo, 1'b0);
        press(5 + $unsigned($random(seed)) % 16, ST_S0);
        foreach (sl[i]) send(i == 0 ? `CMD_S2 : i == 1 ? `CMD_NONE : 3'(5 + i), 1'b1);
        press(8, ST_S1);
        press(8, ST_S0);
        press(60, ST_S5);
        press(8, ST_S0);
        send(`CMD_S1, 1'b0);
        press(60, ST_S5);
        press(8, ST_S0);
        for (int e = 0; e < 2; e++) begin
            en = e[0];
            foreach (sl[s]) for (int src = 0; src < `WAKE_N; src++) if (src != `WAKE_SW) begin
                send(3'(sl[s]), 1'b0);
                a = wake_ok(src, sl[s], en);
                if (a) st_q.push_back(ST_S0);
                if (a) wev_q.push_back(1'b1);
                wk[src] = 1;
                step(1);
                wk[src] = 0;
                step(2);
                if (!a) begin
                    cmp_state(st, sl[s]);
                    send(3'($random(seed)), 1'b1);
                    press(5 + $unsigned($random(seed)) % 16, ST_S0);
                end
            end
        end
        cmp_flag(st_q.size() + rej_q.size() + wev_q.size() == 0, 1'b1);
        report_and_stop;
    end
endmodule
